// >>> pkg/dhi_defines.svh
// Constants of the display host interface
// Summary of operation
// R1 - E mode: read_write_select low writes, high reads
// R2 - data_command_select low command, high display data
// R3 - E mode: latch on strobe fall, selected
// R4 - Host discards one dummy read first
// R5 - Split mode: read ends on read strobe rise
// R6 - Split mode: write taken on write strobe rise
// R7 - 4-wire: shift eight bits MSB first
// R8 - 4-wire: data_command_select sampled on eighth clock
// R9 - Byte written on its completing clock
// R10 - Serial modes are write only
// R11 - D0 serial clock, D1/D2 serial data
// R12 - 3-wire: flag then eight data bits
// R13 - 3-wire: flag one RAM, zero command
// R14 - Two-wire: match address, low bit from pin
// R15 - Two-wire: ignore traffic until address matched
// R16 - Two-wire: direction one read, zero write
// R17 - Two-wire: sense and acknowledge on separate pins
// R18 - Bus mode fixed by strap pins
// R19 - Chip select high ignores bus activity; two-wire mode does not look at chip select
// R20 - Two-wire: acknowledge control and data bytes
// R21 - Control byte: continuation, data/command, six zeros
// R22 - Reset pin clears serial shift register
// R23 - Data bus driven only in read cycle
// R24 - Command read returns status byte
`ifndef DHI_DEFINES_SVH
`define DHI_DEFINES_SVH

// ----------------------------------------------------------------
// Bus mode strap codes
// ----------------------------------------------------------------
`define DHI_MODE_I2C 3'h0
`define DHI_MODE_SPI3 3'h1
`define DHI_MODE_SPI4 3'h2
`define DHI_MODE_E 3'h4
`define DHI_MODE_RW 3'h6

// ----------------------------------------------------------------
// Serial and two-wire constants
// ----------------------------------------------------------------
`define DHI_SPI4_LAST 4'h7
`define DHI_SPI3_LAST 4'h8
`define DHI_I2C_LAST 4'h7
`define DHI_I2C_ADDR_HI 6'h1e
`define DHI_SYNC_W 16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DHI_RST_SHIFT 9'h000
`define DHI_RST_CNT 4'h0
`define DHI_RST_BYTE 8'h00

`endif

// >>> pkg/dhi_pkg.sv
// Types of the display host interface
`include "dhi_defines.svh"
package dhi_pkg;

    // ------------------------------------------------------------
    // Two-wire receiver states, Gray coded in the order listed
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DHI_I_IDLE = 3'h0,
        DHI_I_ADDR = 3'h1,
        DHI_I_CTRL = 3'h3,
        DHI_I_DATA = 3'h2,
        DHI_I_ACK = 3'h6,
        DHI_I_SKIP = 3'h7
    } dhi_i2c_t;

    // ------------------------------------------------------------
    // Whole state of the interface
    // ------------------------------------------------------------
    typedef struct packed {
        logic prev_strobe;
        logic prev_rw;
        logic prev_sclk;
        logic prev_sda;
        logic [8:0] shift;
        logic [3:0] cnt;
        logic [2:0] mode;
        logic mode_ok;
        dhi_i2c_t i2c_st;
        dhi_i2c_t ack_next;
        logic ack_on;
        logic i2c_dc;
        logic i2c_co;
        logic wr_strobe;
        logic [7:0] wr_data;
        logic wr_is_data;
        logic rd_req;
        logic [7:0] rd_latch;
        logic [7:0] d_out;
        logic d_oe_n;
        logic sda_out;
        logic sda_oe_n;
    } dhi_state_t;

endpackage

// >>> core/dhi_sync.sv
// Two-stage pin synchroniser, one stage pair per bit
module dhi_sync
    import dhi_pkg::*;
#(
    parameter int W = 1
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Pins and synchronised copy
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync
);

    logic [W-1:0] meta;

    // ------------------------------------------------------------
    // Per bit flop pair
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    meta[i] <= 1'b0;
                    pin_sync[i] <= 1'b0;
                end
                else
                begin
                    meta[i] <= pin_in[i];
                    pin_sync[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule // dhi_sync

// >>> core/dhi_host_if.sv
// Host bus interface of the display driver: parallel, serial, two-wire
`include "dhi_defines.svh"
module dhi_host_if
    import dhi_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Straps and reset pin
    input wire logic reset_pin_n,
    input wire logic [2:0] bus_mode_pins,
    // Host control pins
    input wire logic chip_select_n,
    input wire logic data_command_select,
    input wire logic bus_strobe,
    input wire logic read_write_select,
    // Host data bus, D0 serial clock, D1 serial data in
    input wire logic [7:0] data_bus_in,
    output logic [7:0] data_bus_out,
    output logic data_bus_oe_n,
    // Two-wire acknowledge drive pin
    output logic sda_drive_out,
    output logic sda_drive_oe_n,
    // Write side toward command register and display RAM
    output logic wr_strobe,
    output logic [7:0] wr_data,
    output logic wr_is_data,
    // Read side from display RAM and status
    output logic ram_rd_req,
    input wire logic [7:0] ram_rdata,
    input wire logic [7:0] status_byte,
    // Strapped mode in use
    output logic [2:0] bus_mode
);

    dhi_state_t s;
    dhi_state_t next_s;
    logic [`DHI_SYNC_W-1:0] pins;
    logic [`DHI_SYNC_W-1:0] sy;
    logic res_s;
    logic [2:0] bs_s;
    logic cs_s;
    logic dc_s;
    logic rw_s;
    logic strobe_s;
    logic [7:0] d_s;
    logic sclk;
    logic serial_data_in;
    logic [7:0] byte_in;
    logic i2c_start;
    logic i2c_stop;
    logic rd_en;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign pins = {reset_pin_n, bus_mode_pins, chip_select_n,
                   data_command_select, read_write_select, bus_strobe,
                   data_bus_in};

    dhi_sync #(.W(`DHI_SYNC_W)) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin_in(pins),
        .pin_sync(sy)
    );

    assign res_s = sy[15];
    assign bs_s = sy[14:12];
    assign cs_s = sy[11];
    assign dc_s = sy[10];
    assign rw_s = sy[9];
    assign strobe_s = sy[8];
    assign d_s = sy[7:0];
    // R11 serial pin roles
    assign sclk = d_s[0];
    assign serial_data_in = d_s[1];
    assign byte_in = {s.shift[6:0], serial_data_in};
    assign i2c_start = sclk && s.prev_sclk && s.prev_sda && !serial_data_in;
    assign i2c_stop = sclk && s.prev_sclk && !s.prev_sda && serial_data_in;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        // R10 serial modes never drive
        rd_en = 1'b0;
        next_s.wr_strobe = 1'b0;
        next_s.rd_req = 1'b0;
        next_s.prev_strobe = strobe_s;
        next_s.prev_rw = rw_s;
        next_s.prev_sclk = sclk;
        next_s.prev_sda = serial_data_in;
        // R4 read data runs one access behind
        if (s.rd_req)
            next_s.rd_latch = ram_rdata;
        // R18 mode caught from straps once
        if (!s.mode_ok)
        begin
            next_s.mode = bs_s;
            next_s.mode_ok = 1'b1;
        end
        else
        begin
            case (s.mode)
                `DHI_MODE_E:
                begin
                    // R1 R3 R19 strobe fall while selected
                    if (s.prev_strobe && !strobe_s && !cs_s)
                    begin
                        if (!rw_s)
                        begin
                            next_s.wr_strobe = 1'b1;
                            next_s.wr_data = d_s;
                            // R2 data or command byte
                            next_s.wr_is_data = dc_s;
                        end
                        else if (dc_s)
                            next_s.rd_req = 1'b1;
                    end
                    rd_en = !cs_s && rw_s && strobe_s;
                end
                `DHI_MODE_RW:
                begin
                    // R6 write strobe rise, read strobe high
                    if (!s.prev_rw && rw_s && !cs_s && strobe_s)
                    begin
                        next_s.wr_strobe = 1'b1;
                        next_s.wr_data = d_s;
                        next_s.wr_is_data = dc_s;
                    end
                    // R5 read strobe rise ends the read
                    if (!s.prev_strobe && strobe_s && !cs_s && rw_s && dc_s)
                        next_s.rd_req = 1'b1;
                    rd_en = !cs_s && !strobe_s && rw_s;
                end
                `DHI_MODE_SPI4, `DHI_MODE_SPI3:
                begin
                    // R19 deselect drops a partial byte
                    if (cs_s)
                        next_s.cnt = `DHI_RST_CNT;
                    else if (!s.prev_sclk && sclk)
                    begin
                        // R7 MSB first shift
                        next_s.shift = {s.shift[7:0], serial_data_in};
                        if ((s.mode == `DHI_MODE_SPI4 &&
                             s.cnt == `DHI_SPI4_LAST) ||
                            (s.mode == `DHI_MODE_SPI3 &&
                             s.cnt == `DHI_SPI3_LAST))
                        begin
                            // R9 write on the completing edge
                            next_s.wr_strobe = 1'b1;
                            next_s.wr_data = byte_in;
                            // R8 R12 R13 pin or leading flag
                            next_s.wr_is_data = (s.mode == `DHI_MODE_SPI4) ?
                                                dc_s : s.shift[7];
                            next_s.cnt = `DHI_RST_CNT;
                        end
                        else
                            next_s.cnt = s.cnt + 4'h1;
                    end
                end
                `DHI_MODE_I2C:
                begin
                    if (i2c_start)
                    begin
                        next_s.i2c_st = DHI_I_ADDR;
                        next_s.cnt = `DHI_RST_CNT;
                        next_s.ack_on = 1'b0;
                        next_s.sda_oe_n = 1'b1;
                    end
                    else if (i2c_stop)
                    begin
                        next_s.i2c_st = DHI_I_IDLE;
                        next_s.ack_on = 1'b0;
                        next_s.sda_oe_n = 1'b1;
                    end
                    else
                    begin
                        case (s.i2c_st)
                            DHI_I_ADDR, DHI_I_CTRL, DHI_I_DATA:
                            begin
                                if (!s.prev_sclk && sclk)
                                begin
                                    next_s.shift = {s.shift[7:0], serial_data_in};
                                    next_s.cnt = s.cnt + 4'h1;
                                    if (s.cnt == `DHI_I2C_LAST)
                                    begin
                                        next_s.cnt = `DHI_RST_CNT;
                                        next_s.i2c_st = DHI_I_ACK;
                                        if (s.i2c_st == DHI_I_ADDR)
                                        begin
                                            // R14 R15 address match
                                            if (byte_in[7:2] !=
                                                `DHI_I2C_ADDR_HI ||
                                                byte_in[1] != dc_s)
                                                next_s.i2c_st = DHI_I_SKIP;
                                            // R16 read has no data source
                                            else if (byte_in[0])
                                                next_s.ack_next = DHI_I_SKIP;
                                            else
                                                next_s.ack_next = DHI_I_CTRL;
                                        end
                                        else if (s.i2c_st == DHI_I_CTRL)
                                        begin
                                            // R21 control byte fields
                                            next_s.i2c_co = byte_in[7];
                                            next_s.i2c_dc = byte_in[6];
                                            next_s.ack_next = DHI_I_DATA;
                                        end
                                        else
                                        begin
                                            next_s.wr_strobe = 1'b1;
                                            next_s.wr_data = byte_in;
                                            next_s.wr_is_data = s.i2c_dc;
                                            next_s.ack_next = s.i2c_co ?
                                                DHI_I_CTRL : DHI_I_DATA;
                                        end
                                    end
                                end
                            end
                            DHI_I_ACK:
                            begin
                                // R17 R20 ack held over the ninth clock
                                if (s.prev_sclk && !sclk)
                                begin
                                    next_s.ack_on = !s.ack_on;
                                    next_s.sda_oe_n = s.ack_on;
                                    if (s.ack_on)
                                        next_s.i2c_st = s.ack_next;
                                end
                            end
                            DHI_I_IDLE, DHI_I_SKIP:
                                next_s.i2c_st = s.i2c_st;
                            default:
                                next_s.i2c_st = DHI_I_IDLE;
                        endcase
                    end
                end
                default:
                    next_s.cnt = `DHI_RST_CNT;
            endcase
        end
        // R23 R24 drive only inside a selected read
        if (rd_en)
        begin
            next_s.d_oe_n = 1'b0;
            next_s.d_out = dc_s ? s.rd_latch : status_byte;
        end
        else
            next_s.d_oe_n = 1'b1;
        // R22 reset pin wipes serial state, straps reread
        if (!res_s)
        begin
            next_s.shift = `DHI_RST_SHIFT;
            next_s.cnt = `DHI_RST_CNT;
            next_s.i2c_st = DHI_I_IDLE;
            next_s.ack_on = 1'b0;
            next_s.sda_oe_n = 1'b1;
            next_s.d_oe_n = 1'b1;
            next_s.mode_ok = 1'b0;
            next_s.wr_strobe = 1'b0;
            next_s.rd_req = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s <= '0;
            s.i2c_st <= DHI_I_IDLE;
            s.ack_next <= DHI_I_IDLE;
            s.d_oe_n <= 1'b1;
            s.sda_oe_n <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign data_bus_out = s.d_out;
    assign data_bus_oe_n = s.d_oe_n;
    assign sda_drive_out = s.sda_out;
    assign sda_drive_oe_n = s.sda_oe_n;
    assign wr_strobe = s.wr_strobe;
    assign wr_data = s.wr_data;
    assign wr_is_data = s.wr_is_data;
    assign ram_rd_req = s.rd_req;
    assign bus_mode = s.mode;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    a_e_write_latch: assert property ( // R3
        s.mode_ok && s.mode == `DHI_MODE_E && res_s && s.prev_strobe &&
        !strobe_s && !cs_s && !rw_s
        |=> wr_strobe && wr_data == $past(d_s) && wr_is_data == $past(dc_s))
        else $error("E mode write not latched");

    a_split_write: assert property ( // R6
        s.mode_ok && s.mode == `DHI_MODE_RW && res_s && !s.prev_rw &&
        rw_s && !cs_s && strobe_s
        |=> wr_strobe && wr_data == $past(d_s))
        else $error("Split mode write not taken");

    a_split_read: assert property ( // R5
        s.mode_ok && s.mode == `DHI_MODE_RW && res_s && !s.prev_strobe &&
        strobe_s && !cs_s && rw_s && dc_s
        |=> ram_rd_req ##1 (s.rd_latch == $past(ram_rdata)))
        else $error("Split mode read not completed");

    a_deselect_quiet: assert property ( // R19
        cs_s && s.mode != `DHI_MODE_I2C && s.mode_ok
        |=> !wr_strobe && !ram_rd_req && data_bus_oe_n)
        else $error("Activity while deselected");

    a_status_read: assert property ( // R24
        !data_bus_oe_n && !$past(dc_s) |-> data_bus_out == $past(status_byte))
        else $error("Command read not status");

    a_serial_noread: assert property ( // R10
        s.mode == `DHI_MODE_SPI4 || s.mode == `DHI_MODE_SPI3 ||
        s.mode == `DHI_MODE_I2C |=> data_bus_oe_n)
        else $error("Data bus driven in serial mode");

    a_spi_count: assert property ( // R12
        s.mode == `DHI_MODE_SPI3 && wr_strobe |-> $past(s.cnt) == 4'h8)
        else $error("3-wire byte not on ninth clock");

    a_pin_reset: assert property ( // R22
        !res_s |=> s.shift == 9'h000 && s.cnt == 4'h0 && !wr_strobe)
        else $error("Reset pin did not clear shift");

    a_mode_stable: assert property ( // R18
        s.mode_ok && $past(s.mode_ok) |-> $stable(bus_mode))
        else $error("Bus mode changed without reset");

    a_skip_silent: assert property ( // R15
        s.i2c_st == DHI_I_SKIP |-> sda_drive_oe_n && !wr_strobe)
        else $error("Unaddressed two-wire traffic answered");

    a_ack_span: assert property ( // R20
        !sda_drive_oe_n |-> s.i2c_st == DHI_I_ACK && s.ack_on)
        else $error("Acknowledge outside ack phase");

endmodule // dhi_host_if

// >>> verif/dhi_host_model.sv
// Host microcontroller model driving the display interface pins
module dhi_host_model (
    // Clock
    input wire logic mclk,
    // Device side of the shared pins
    input wire logic [7:0] dev_dout,
    input wire logic dev_oe_n,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // Host pins toward the device
    output logic cs_n,
    output logic dc,
    output logic strobe,
    output logic rw,
    output logic [7:0] dbus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] dq;
    logic ser;
    logic scl;
    logic sdo;
    logic sw;
    // open-drain wire, pull-up when nobody pulls low
    assign sw = sdo & (sda_oe_n | sda_out);
    // serial clock on D0, data on tied D1/D2
    assign dbus = ser ? {5'h00, sw, sw, scl} :
        ((dev_oe_n === 1'b0) ? dev_dout : dq);

    initial
    begin
        cs_n = 1'b1;
        dc = 1'b0;
        strobe = 1'b0;
        rw = 1'b0;
        dq = 8'h00;
        ser = 1'b0;
        scl = 1'b0;
        sdo = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // ----------------------------------------------------------------
    // Parallel cycle, E strobe or split strobes
    // ----------------------------------------------------------------
    // direction and data/command settle before the strobe
    task automatic par(input bit e, input bit rd, input bit d_c,
                       input logic [7:0] b, input bit cs,
                       output logic [7:0] q);
        ser = 1'b0;
        strobe = !e;
        rw = e ? rd : 1'b1;
        dc = d_c;
        // Released bus shows the inverse, never a stale match
        dq = rd ? ~dq : b;
        wt(3);
        cs_n = !cs;
        wt(3);
        strobe = e ? 1'b1 : !rd;
        rw = rd;
        wt(6);
        q = dev_dout;
        strobe = !e;
        rw = e ? rd : 1'b1;
        wt(3);
        cs_n = 1'b1;
        wt(2);
    endtask

    // ----------------------------------------------------------------
    // Serial word, write only
    // ----------------------------------------------------------------
    // data/command held across the word, no reads issued
    task automatic spi(input int n, input logic [8:0] w, input bit d_c,
                       input bit fin);
        ser = 1'b1;
        scl = 1'b0;
        cs_n = 1'b0;
        dc = d_c;
        for (int i = n - 1; i >= 0; i--)
        begin
            sdo = w[i];
            wt(4);
            scl = 1'b1;
            wt(4);
            scl = 1'b0;
        end
        sdo = ~sdo;
        wt(2);
        cs_n = fin;
        wt(4);
    endtask

    // ----------------------------------------------------------------
    // Two-wire framing
    // ----------------------------------------------------------------
    task automatic i2c_start(input bit sa0);
        ser = 1'b1;
        dc = sa0;
        sdo = 1'b1;
        scl = 1'b1;
        wt(4);
        sdo = 1'b0;
        wt(4);
        scl = 1'b0;
    endtask

    // host frames bytes, reads ack off the shared wire
    task automatic i2c_byte(input logic [7:0] b, output bit ack);
        for (int i = 7; i >= -1; i--)
        begin
            sdo = (i < 0) ? 1'b1 : b[i];
            wt(4);
            scl = 1'b1;
            wt(4);
            ack = !sw;
            scl = 1'b0;
        end
    endtask

    task automatic i2c_stop();
        sdo = 1'b0;
        wt(4);
        scl = 1'b1;
        wt(4);
        sdo = 1'b1;
        wt(4);
    endtask
endmodule // dhi_host_model

// >>> verif/dhi_host_if_tb.sv
// Self-checking bench of the display host interface
`include "dhi_defines.svh"
module dhi_host_if_tb
    import dhi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic sys_rst, reset_pin_n, cs_n, dc, strobe, rw, oe_n;
    logic sda_out, sda_oe_n, wr_strobe, wr_is_data, ram_rd_req;
    logic [2:0] bus_mode_pins, bus_mode;
    logic [7:0] dbus, dout, wr_data, ram_rdata, status_byte;
    logic [8:0] exp_q[$];
    bit fetched = 1'b0;
    int num_errors = 0;
    int cmp_count = 0;

    always #50 mclk = ~mclk;

    dhi_host_if u_dut (.mclk(mclk), .sys_rst(sys_rst),
        .reset_pin_n(reset_pin_n), .bus_mode_pins(bus_mode_pins),
        .chip_select_n(cs_n), .data_command_select(dc),
        .bus_strobe(strobe), .read_write_select(rw),
        .data_bus_in(dbus), .data_bus_out(dout), .data_bus_oe_n(oe_n),
        .sda_drive_out(sda_out), .sda_drive_oe_n(sda_oe_n),
        .wr_strobe(wr_strobe), .wr_data(wr_data), .wr_is_data(wr_is_data),
        .ram_rd_req(ram_rd_req), .ram_rdata(ram_rdata),
        .status_byte(status_byte), .bus_mode(bus_mode));

    dhi_host_model u_host (.mclk(mclk), .dev_dout(dout), .dev_oe_n(oe_n),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cs_n(cs_n), .dc(dc),
        .strobe(strobe), .rw(rw), .dbus(dbus));

    // Display RAM stand-in, steps one cycle after every fetch
    always @(negedge mclk)
    begin
        if (fetched)
            ram_rdata = ram_rdata + 8'h01;
        fetched = (ram_rd_req === 1'b1);
    end

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("Error at %0t ns: %s", $time, msg);
        end
    endtask

    // ----------------------------------------------------------------
    // Write monitor
    // ----------------------------------------------------------------
    always @(negedge mclk)
    begin
        if (wr_strobe === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(1'b0, "unexpected write");
            else
                chk({wr_is_data, wr_data} === exp_q.pop_front(),
                    "write mismatch");
        end
    end

    task automatic stop_test();
        $display("Checks %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic set_mode(input logic [2:0] m);
        sys_rst = 1'b1;
        bus_mode_pins = m;
        repeat (3) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (6) @(negedge mclk);
        chk(bus_mode === m, "bus mode");
    endtask

    // Bounded wait, then quiet time to catch stray writes
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 80)
        begin
            @(negedge mclk);
            n++;
        end
        repeat (8) @(negedge mclk);
        chk(exp_q.size() == 0, "missing write");
    endtask

    initial
    begin
        repeat (100000) @(posedge mclk);
        num_errors++;
        $display("Error at %0t ns: run timeout", $time);
        stop_test();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [7:0] q;
        logic [7:0] b;
        logic [2:0] pm [2];
        bit a;
        bit e;
        sys_rst = 1'b1;
        reset_pin_n = 1'b1;
        bus_mode_pins = `DHI_MODE_E;
        ram_rdata = 8'h5a;
        status_byte = 8'h00;
        pm[0] = `DHI_MODE_E;
        pm[1] = `DHI_MODE_RW;
        void'($urandom(32'he01c));
        repeat (20) @(negedge mclk);
        foreach (pm[k])
        begin
            set_mode(pm[k]);
            e = (pm[k] == `DHI_MODE_E);
            for (int i = 0; i < 2; i++)
            begin
                b = 8'($urandom());
                exp_q.push_back({i[0], b});
                u_host.par(e, 1'b0, i[0], b, 1'b1, q);
            end
            u_host.par(e, 1'b0, 1'b1, 8'h3c, 1'b0, q);
            drain();
            status_byte = 8'($urandom());
            u_host.par(e, 1'b1, 1'b0, 8'h00, 1'b1, q);
            chk(q === status_byte, "status read");
            b = ram_rdata;
            u_host.par(e, 1'b1, 1'b1, 8'h00, 1'b1, q);
            u_host.par(e, 1'b1, 1'b1, 8'h00, 1'b1, q);
            chk(q === b, "ram read");
            chk(oe_n === 1'b1, "bus released");
        end
        set_mode(`DHI_MODE_SPI4);
        for (int i = 0; i < 4; i++)
        begin
            b = 8'($urandom());
            exp_q.push_back({i[0], b});
            u_host.spi(8, {1'b0, b}, i[0], 1'b1);
        end
        // Half a byte, then the reset pin must drop it
        u_host.spi(4, 9'h00f, 1'b1, 1'b0);
        reset_pin_n = 1'b0;
        repeat (4) @(negedge mclk);
        reset_pin_n = 1'b1;
        repeat (6) @(negedge mclk);
        b = 8'($urandom());
        exp_q.push_back({1'b1, b});
        u_host.spi(8, {1'b0, b}, 1'b1, 1'b1);
        drain();
        set_mode(`DHI_MODE_SPI3);
        for (int i = 0; i < 2; i++)
        begin
            b = 8'($urandom());
            exp_q.push_back({i[0], b});
            u_host.spi(9, {i[0], b}, 1'b0, 1'b1);
        end
        drain();
        set_mode(`DHI_MODE_I2C);
        for (int i = 0; i < 2; i++)
        begin
            b = 8'($urandom());
            exp_q.push_back({i[0], b});
            exp_q.push_back({i[0], ~b});
            u_host.i2c_start(i[0]);
            u_host.i2c_byte({6'b011110, i[0], 1'b0}, a);
            chk(a === 1'b1, "address ack");
            u_host.i2c_byte({1'b0, i[0], 6'b000000}, a);
            chk(a === 1'b1, "control ack");
            u_host.i2c_byte(b, a);
            chk(a === 1'b1, "data ack");
            u_host.i2c_byte(~b, a);
            chk(a === 1'b1, "data ack");
            u_host.i2c_stop();
        end
        // Foreign address: no ack, following bytes dropped
        u_host.i2c_start(1'b0);
        u_host.i2c_byte({6'b011110, 1'b1, 1'b0}, a);
        chk(a === 1'b0, "foreign address");
        u_host.i2c_byte(8'h40, a);
        u_host.i2c_byte(8'h55, a);
        chk(a === 1'b0, "ignored data");
        u_host.i2c_stop();
        u_host.i2c_start(1'b1);
        u_host.i2c_byte({6'b011110, 1'b1, 1'b1}, a);
        chk(a === 1'b1, "read address ack");
        u_host.i2c_stop();
        drain();
        stop_test();
    end
endmodule // dhi_host_if_tb
